// [ipc_config.sv]
/*
 * Interrupt priority configuration: two priority control registers behind AXI4-Lite,
 * per-source enable by nonzero priority, and a registered winner of the pending sources.
 * Assumes source requests are synchronous levels on sys_clk; one clock, no interrupt logic.
 */
`timescale 1ns/100ps

module ipc_config (
   input  wire logic                              sys_clk,        // 125 MHz clock
   input  wire logic                              nrst,           // async reset, low
   // AXI4-Lite write address
   input  wire logic                              s_axi_awvalid,  // address valid
   output logic                                   s_axi_awready,  // address taken
   input  wire logic [ipc_pkg::IPC_ADDR_W-1:0]    s_axi_awaddr,   // byte address
   // AXI4-Lite write data
   input  wire logic                              s_axi_wvalid,   // data valid
   output logic                                   s_axi_wready,   // data taken
   input  wire logic [ipc_pkg::IPC_DATA_W-1:0]    s_axi_wdata,    // write data
   input  wire logic [ipc_pkg::IPC_STRB_W-1:0]    s_axi_wstrb,    // byte enables
   // AXI4-Lite write response
   output logic                                   s_axi_bvalid,   // response valid
   input  wire logic                              s_axi_bready,   // response taken
   output logic [1:0]                             s_axi_bresp,    // response code
   // AXI4-Lite read address
   input  wire logic                              s_axi_arvalid,  // address valid
   output logic                                   s_axi_arready,  // address taken
   input  wire logic [ipc_pkg::IPC_ADDR_W-1:0]    s_axi_araddr,   // byte address
   // AXI4-Lite read data
   output logic                                   s_axi_rvalid,   // data valid
   input  wire logic                              s_axi_rready,   // data taken
   output logic [ipc_pkg::IPC_DATA_W-1:0]         s_axi_rdata,    // read data
   output logic [1:0]                             s_axi_rresp,    // response code
   // Interrupt sources and arbitration result
   input  wire logic [ipc_pkg::IPC_NUM_SRC-1:0]   src_req,        // source request levels
   output logic                                   irq_pending,    // enabled request exists
   output logic [ipc_pkg::IPC_SRC_IDX_W-1:0]      irq_source,     // winning source index
   output logic [ipc_pkg::IPC_PRIO_W-1:0]         irq_level,      // winning priority
   output logic [ipc_pkg::IPC_SUB_W-1:0]          irq_subpriority // winning subpriority
);
   import ipc_pkg::*;

   // ****************************************************************
   // Register storage
   // ****************************************************************
   logic [IPC_DATA_W-1:0]    ctrl_r [IPC_NUM_REGS];
   logic [IPC_DATA_W-1:0]    ctrl_nxt [IPC_NUM_REGS];

   // Write channel state
   ipc_wr_state_t            wstate_r;
   logic                     aw_held_r;
   logic [IPC_ADDR_W-1:0]    awaddr_r;
   logic                     w_held_r;
   logic [IPC_DATA_W-1:0]    wdata_r;
   logic [IPC_STRB_W-1:0]    wstrb_r;
   logic [1:0]               bresp_r;

   // Read channel state
   logic                     rvalid_r;
   logic [IPC_DATA_W-1:0]    rdata_r;
   logic [1:0]               rresp_r;

   // Arbitration result
   logic                     pend_r;
   logic [IPC_SRC_IDX_W-1:0] src_r;
   logic [IPC_PRIO_W-1:0]    lvl_r;
   logic [IPC_SUB_W-1:0]     sub_r;
   logic [IPC_NUM_SRC-1:0]   en_req_r;

   // ****************************************************************
   // Write channel decode
   // ****************************************************************
   // Commit only in the collect state: an address taken while the
   // response waits is parked until the master accepts that response.
   wire aw_fire    = s_axi_awvalid & s_axi_awready;
   wire w_fire     = s_axi_wvalid & s_axi_wready;
   wire b_fire     = s_axi_bvalid & s_axi_bready;
   wire do_write   = (wstate_r == IPC_WS_COLLECT) & aw_held_r & w_held_r;
   wire wr_ctrl7   = do_write & (awaddr_r == IPC_OFS_CTRL7);
   wire wr_ctrl8   = do_write & (awaddr_r == IPC_OFS_CTRL8);
   wire wr_status  = do_write & (awaddr_r == IPC_OFS_STATUS);
   wire wr_mapped  = wr_ctrl7 | wr_ctrl8 | wr_status;
   wire [1:0] wr_resp = wr_mapped ? IPC_RESP_OKAY : IPC_RESP_SLVERR;

   // Each channel takes one item and then holds it until the commit
   assign s_axi_awready = ~aw_held_r;
   assign s_axi_wready  = ~w_held_r;
   assign s_axi_bvalid  = (wstate_r == IPC_WS_RESP);
   assign s_axi_bresp   = bresp_r;

   // ****************************************************************
   // Byte-lane merge of write data
   // ****************************************************************
   // Reserved lane bits are stored as zero whatever is written, so a careless
   // writer cannot park state in them.
   generate
      for (genvar b = 0; b < IPC_STRB_W; b++) begin : g_lane
         wire [7:0] lane_in = wdata_r[b*IPC_LANE_W +: IPC_LANE_W] & IPC_LANE_MASK;
         wire       take7   = wr_ctrl7 & wstrb_r[b];
         wire       take8   = wr_ctrl8 & wstrb_r[b];
         assign ctrl_nxt[0][b*IPC_LANE_W +: IPC_LANE_W] =
            take7 ? lane_in : ctrl_r[0][b*IPC_LANE_W +: IPC_LANE_W];
         assign ctrl_nxt[1][b*IPC_LANE_W +: IPC_LANE_W] =
            take8 ? lane_in : ctrl_r[1][b*IPC_LANE_W +: IPC_LANE_W];
      end
   endgenerate

   // Address and data capture, independent order
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aw_held_r <= 1'b0;
         awaddr_r  <= '0;
      end else if (aw_fire) begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         w_held_r <= 1'b0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
      end else if (w_fire) begin
         w_held_r <= 1'b1;
         wdata_r  <= s_axi_wdata;
         wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
         w_held_r <= 1'b0;
      end
   end

   // Commit and response sequencing
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wstate_r <= IPC_WS_COLLECT;
         bresp_r  <= IPC_RESP_OKAY;
      end else begin
         case (wstate_r)
            IPC_WS_COLLECT: begin
               if (do_write) begin
                  wstate_r <= IPC_WS_RESP;
                  bresp_r  <= wr_resp;
               end
            end
            IPC_WS_RESP: begin
               if (b_fire) begin
                  wstate_r <= IPC_WS_COLLECT;
               end
            end
            default: begin
               wstate_r <= IPC_WS_COLLECT;
            end
         endcase
      end
   end

   // Lanes merge a byte at a time, so a partial-strobe write leaves the
   // other sources of the same register untouched.
   // Priority control registers, all writable fields clear at reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r[0] <= IPC_REG_RESET;
         ctrl_r[1] <= IPC_REG_RESET;
      end else begin
         ctrl_r[0] <= ctrl_nxt[0];
         ctrl_r[1] <= ctrl_nxt[1];
      end
   end

   // ****************************************************************
   // Per-source fields and enable
   // ****************************************************************
   // Source i lives in register i/4, byte lane i%4: this places comparator one
   // at 12-10/9-8 and the parallel port at 4-2/1-0 of the first register, and the
   // calendar, monitor, twowire and serial port lanes high to low in the second.
   logic [IPC_NUM_SRC*IPC_PRIO_W-1:0] prio_flat;
   logic [IPC_NUM_SRC*IPC_SUB_W-1:0]  sub_flat;
   logic [IPC_NUM_SRC-1:0]            src_en;

   generate
      for (genvar s = 0; s < IPC_NUM_SRC; s++) begin : g_src
         localparam int REG  = s / IPC_SRC_PER_REG;
         localparam int LANE = s % IPC_SRC_PER_REG;
         wire [IPC_PRIO_W-1:0] prio_s =
            ctrl_r[REG][LANE*IPC_LANE_W + IPC_PRIO_LSB +: IPC_PRIO_W];
         wire [IPC_SUB_W-1:0]  sub_s  =
            ctrl_r[REG][LANE*IPC_LANE_W + IPC_SUB_LSB +: IPC_SUB_W];
         assign prio_flat[s*IPC_PRIO_W +: IPC_PRIO_W] = prio_s;
         assign sub_flat[s*IPC_SUB_W +: IPC_SUB_W]    = sub_s;
         // A zero priority masks the request outright
         assign src_en[s] = src_req[s] & (prio_s != IPC_PRIO_OFF);
      end
   endgenerate

   // ****************************************************************
   // Ranking
   // ****************************************************************
   logic                     win_valid;
   logic [IPC_SRC_IDX_W-1:0] win_idx;
   logic [IPC_PRIO_W-1:0]    win_lvl;
   logic [IPC_SUB_W-1:0]     win_sub;

   // Ties fall to the lower source index; software wanting another order
   // must give the sources distinct subpriorities.
   ipc_rank #(
      .N  (IPC_NUM_SRC),
      .PW (IPC_PRIO_W),
      .SW (IPC_SUB_W),
      .IW (IPC_SRC_IDX_W)
   ) u_rank (
      .en        (src_en),
      .prio_flat (prio_flat),
      .sub_flat  (sub_flat),
      .win_valid (win_valid),
      .win_idx   (win_idx),
      .win_lvl   (win_lvl),
      .win_sub   (win_sub)
   );

   // The register costs a cycle of latency but keeps the ranking chain
   // off the outputs and off the status read path.
   // Registered result, one cycle behind requests and settings
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pend_r   <= 1'b0;
         src_r    <= '0;
         lvl_r    <= '0;
         sub_r    <= '0;
         en_req_r <= '0;
      end else begin
         pend_r   <= win_valid;
         src_r    <= win_idx;
         lvl_r    <= win_lvl;
         sub_r    <= win_sub;
         en_req_r <= src_en;
      end
   end

   assign irq_pending     = pend_r;
   assign irq_source      = src_r;
   assign irq_level       = lvl_r;
   assign irq_subpriority = sub_r;

   // ****************************************************************
   // Read channel
   // ****************************************************************
   wire ar_fire = s_axi_arvalid & s_axi_arready;
   wire r_fire  = s_axi_rvalid & s_axi_rready;

   // The enable field lags the pins by one cycle like the winner, so a
   // read returns one consistent snapshot.
   // Status word gathers the live arbitration state
   wire [IPC_DATA_W-1:0] status_word =
      (IPC_DATA_W'(pend_r)   << IPC_ST_VALID_BIT) |
      (IPC_DATA_W'(en_req_r) << IPC_ST_PEND_LSB)  |
      (IPC_DATA_W'(src_r)    << IPC_ST_SRC_LSB)   |
      (IPC_DATA_W'(lvl_r)    << IPC_ST_LVL_LSB)   |
      (IPC_DATA_W'(sub_r)    << IPC_ST_SUB_LSB);

   wire rd_ctrl7  = (s_axi_araddr == IPC_OFS_CTRL7);
   wire rd_ctrl8  = (s_axi_araddr == IPC_OFS_CTRL8);
   wire rd_status = (s_axi_araddr == IPC_OFS_STATUS);
   wire rd_mapped = rd_ctrl7 | rd_ctrl8 | rd_status;

   // Decode straight from the address pins; they are only looked at on
   // the accepting edge, so no address register is needed.
   // Reserved bits read back as stored zero
   wire [IPC_DATA_W-1:0] rd_mux =
      rd_ctrl7  ? ctrl_r[0] :
      rd_ctrl8  ? ctrl_r[1] :
      rd_status ? status_word : '0;

   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // A response code is kept with the data so an unmapped read is refused
   // without touching any register.
   // Only one read outstanding; data held until taken
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rvalid_r <= 1'b0;
         rdata_r  <= '0;
         rresp_r  <= IPC_RESP_OKAY;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= rd_mapped ? IPC_RESP_OKAY : IPC_RESP_SLVERR;
      end else if (r_fire) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule : ipc_config

// [ipc_pkg.sv]
/*
 * Constants, field layouts and types for the interrupt priority configuration block.
 * Assumes a single 125 MHz system clock and an AXI4-Lite register bus with 32-bit data.
 */
package ipc_pkg;

   // ****************************************************************
   // Bus geometry
   // ****************************************************************
   localparam int          IPC_ADDR_W      = 4;
   localparam int          IPC_DATA_W      = 32;
   localparam int          IPC_STRB_W      = IPC_DATA_W / 8;
   localparam int          IPC_NUM_REGS    = 2;

   // Register byte offsets
   localparam logic [3:0]  IPC_OFS_CTRL7   = 4'h0;  // priority_control_seven
   localparam logic [3:0]  IPC_OFS_CTRL8   = 4'h4;  // priority_control_eight
   localparam logic [3:0]  IPC_OFS_STATUS  = 4'h8;  // arbitration status, read only

   // ****************************************************************
   // Field layout: one source per byte lane
   // ****************************************************************
   localparam int          IPC_SRC_PER_REG = 4;
   localparam int          IPC_NUM_SRC     = IPC_NUM_REGS * IPC_SRC_PER_REG;
   localparam int          IPC_SRC_IDX_W   = 3;
   localparam int          IPC_LANE_W      = 8;
   localparam int          IPC_PRIO_LSB    = 2;
   localparam int          IPC_PRIO_W      = 3;
   localparam int          IPC_SUB_LSB     = 0;
   localparam int          IPC_SUB_W       = 2;
   localparam logic [7:0]  IPC_LANE_MASK   = 8'h1f;        // reserved bits 7..5 of each lane
   localparam logic [31:0] IPC_REG_RESET   = 32'h00000000;
   localparam logic [2:0]  IPC_PRIO_OFF    = 3'h0;

   // Source index = register * 4 + byte lane
   localparam int          IPC_SRC_PARALLEL_PORT = 0;
   localparam int          IPC_SRC_COMPARATOR_1  = 1;
   localparam int          IPC_SRC_COMPARATOR_2  = 2;
   localparam int          IPC_SRC_SERIAL_PERIPH = 3;
   localparam int          IPC_SRC_SERIAL_PORT_2 = 4;
   localparam int          IPC_SRC_TWOWIRE_2     = 5;
   localparam int          IPC_SRC_CLOCK_MONITOR = 6;
   localparam int          IPC_SRC_CALENDAR      = 7;

   // ****************************************************************
   // Status register layout
   // ****************************************************************
   localparam int          IPC_ST_VALID_BIT = 31;
   localparam int          IPC_ST_PEND_LSB  = 16;
   localparam int          IPC_ST_SRC_LSB   = 8;
   localparam int          IPC_ST_LVL_LSB   = 2;
   localparam int          IPC_ST_SUB_LSB   = 0;

   // AXI responses
   localparam logic [1:0]  IPC_RESP_OKAY   = 2'b00;
   localparam logic [1:0]  IPC_RESP_SLVERR = 2'b10;

   // Write channel sequencing
   typedef enum logic [0:0] {
      IPC_WS_COLLECT,
      IPC_WS_RESP
   } ipc_wr_state_t;

endpackage : ipc_pkg

// [ipc_rank.sv]
/*
 * Combinational ranking of enabled interrupt sources by priority then subpriority.
 * Assumes requests arrive already gated by the caller; lower index wins a full tie.
 */
`timescale 1ns/100ps
module ipc_rank #(
   parameter int N  = 8,   // number of sources
   parameter int PW = 3,   // priority width
   parameter int SW = 2,   // subpriority width
   parameter int IW = 3    // source index width
) (
   input  wire logic [N-1:0]    en,        // enabled, pending sources
   input  wire logic [N*PW-1:0] prio_flat, // priority per source
   input  wire logic [N*SW-1:0] sub_flat,  // subpriority per source
   output logic                 win_valid, // some source wins
   output logic [IW-1:0]        win_idx,   // winning source
   output logic [PW-1:0]        win_lvl,   // its priority
   output logic [SW-1:0]        win_sub    // its subpriority
);
   import ipc_pkg::*;

   logic          c_valid [N+1];
   logic [IW-1:0] c_idx   [N+1];
   logic [PW-1:0] c_lvl   [N+1];
   logic [SW-1:0] c_sub   [N+1];

   // Empty candidate at the head of the chain
   assign c_valid[0] = 1'b0;
   assign c_idx[0]   = '0;
   assign c_lvl[0]   = '0;
   assign c_sub[0]   = '0;

   // ****************************************************************
   // Chain of compare stages, one per source
   // ****************************************************************
   generate
      for (genvar i = 0; i < N; i++) begin : g_stage
         wire [PW-1:0] lvl_i = prio_flat[i*PW +: PW];
         wire [SW-1:0] sub_i = sub_flat[i*SW +: SW];
         // Strict compare keeps the earlier source on a tie
         wire take_i = en[i] && (!c_valid[i] || (lvl_i > c_lvl[i]) ||
                       ((lvl_i == c_lvl[i]) && (sub_i > c_sub[i])));
         assign c_valid[i+1] = c_valid[i] | en[i];
         assign c_idx[i+1]   = take_i ? IW'(i) : c_idx[i];
         assign c_lvl[i+1]   = take_i ? lvl_i : c_lvl[i];
         assign c_sub[i+1]   = take_i ? sub_i : c_sub[i];
      end
   endgenerate

   assign win_valid = c_valid[N];
   assign win_idx   = c_idx[N];
   assign win_lvl   = c_lvl[N];
   assign win_sub   = c_sub[N];

endmodule : ipc_rank

// [ipc_monitor.sv]
/*
 * Checker for the priority configuration block: bus handshakes and winner outputs.
 * Assumes one clock domain and sight of the top module ports only.
 */
`timescale 1ns/100ps
module ipc_monitor (
   input wire logic                              sys_clk,        // system clock
   input wire logic                              nrst,           // async reset, low
   input wire logic                              s_axi_awvalid,  // address valid
   input wire logic                              s_axi_awready,  // address taken
   input wire logic                              s_axi_wvalid,   // data valid
   input wire logic                              s_axi_wready,   // data taken
   input wire logic                              s_axi_bvalid,   // response valid
   input wire logic                              s_axi_arvalid,  // read address valid
   input wire logic                              s_axi_arready,  // read address taken
   input wire logic                              s_axi_rvalid,   // read data valid
   input wire logic                              s_axi_rready,   // read data taken
   input wire logic [ipc_pkg::IPC_NUM_SRC-1:0]   src_req,        // source requests
   input wire logic                              irq_pending,    // winner present
   input wire logic [ipc_pkg::IPC_SRC_IDX_W-1:0] irq_source,     // winner index
   input wire logic [ipc_pkg::IPC_PRIO_W-1:0]    irq_level       // winner priority
);
   import ipc_pkg::*;

   // ****************************************************************
   // Helper state
   // ****************************************************************
   logic [IPC_NUM_SRC-1:0] req_q;  // Requests one edge back

   // Keep what the ranking saw, so a winner can be traced to its cause
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         req_q <= '0;
      end else begin
         req_q <= src_req;
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   property p_pend_level; irq_pending |-> irq_level != IPC_PRIO_OFF; endproperty
   a_pend_level: assert property (p_pend_level) else $error("winner at level zero");
   property p_idle; !(|src_req) |=> !irq_pending; endproperty
   a_idle: assert property (p_idle) else $error("pending with no request");
   property p_src_live; irq_pending |-> req_q[irq_source]; endproperty
   a_src_live: assert property (p_src_live) else $error("winner not requesting");
   property p_wr_commit;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid
         |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_wr_commit: assert property (p_wr_commit) else $error("write response late");
   property p_aw_busy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
   a_aw_busy: assert property (p_aw_busy) else $error("second address accepted");
   property p_rd_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_rd_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
   a_rd_done: assert property (p_rd_done) else $error("read data repeated");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while busy");

   // Main scenarios reached
   c_write: cover property (s_axi_bvalid);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_top: cover property (irq_pending && irq_level == 3'h7);
endmodule : ipc_monitor

bind ipc_config ipc_monitor u_mon (
   .sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .src_req(src_req),
   .irq_pending(irq_pending), .irq_source(irq_source), .irq_level(irq_level)
);

// [tb.sv]
/*
 * Self-checking bench for the priority configuration block with a reference model.
 * Assumes the design answers AXI4-Lite at its own pace; the bench owns every input.
 */
`timescale 1ns/100ps
module tb;
   import ipc_pkg::*;

   // ****************************************************************
   // Stimulus, observation and model state
   // ****************************************************************
   logic        sys_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq_pending;
   logic [3:0]  awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, d;
   logic [1:0]  bresp, rresp, r, irq_subpriority;
   logic [7:0]  src_req;
   logic [2:0]  irq_source, irq_level;
   logic [31:0] m [2];  // Model copies of the two registers
   int          bad_count, checked, i, p, s;

   ipc_config u_dut (
      .sys_clk(sys_clk), .nrst(nrst), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .src_req(src_req), .irq_pending(irq_pending),
      .irq_source(irq_source), .irq_level(irq_level), .irq_subpriority(irq_subpriority)
   );

   // 125 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic stop_test;
      $display("mismatches %0d, comparisons %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // A wait that ran out ends the run as a failure
   task automatic limit(input int n);
      if (n >= 100) begin
         bad_count++;
         stop_test();
      end
   endtask : limit

   // Both write channels offered together; each released once taken
   task automatic axi_write(input logic [3:0] a, input logic [31:0] dat,
                            input logic [3:0] st, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge sys_clk);
      awaddr  <= a;
      wdata   <= dat;
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready) && n < 100);
      bready <= 1'b0;
      limit(n);
      check(32'(bresp), 32'(er));
      for (int b = 0; b < 4; b++) begin
         if (a < IPC_OFS_STATUS && st[b]) m[a[2]][b*8 +: 8] = dat[b*8 +: 8] & IPC_LANE_MASK;
      end
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] rs);
      int n;
      n = 0;
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready) && n < 100);
      rready <= 1'b0;
      dat = rdata;
      rs  = rresp;
      limit(n);
   endtask : axi_read

   task automatic rd_check(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
      axi_read(a, d, r);
      check(d, exp);
      check(32'(r), 32'(er));
   endtask : rd_check

   // Highest level, then highest subpriority; strict compare keeps the lower index on ties
   function automatic logic [8:0] model_win(input logic [7:0] req);
      logic [8:0] best;
      logic [7:0] lane;
      best = '0;
      for (int k = 0; k < 8; k++) begin
         lane = m[k / 4][(k % 4) * 8 +: 8];
         if (req[k] && lane[4:2] != 3'h0 && (!best[8] || lane[4:0] > best[4:0])) begin
            best = {1'b1, 3'(k), lane[4:0]};
         end
      end
      return best;
   endfunction : model_win

   task automatic check_irq(input logic [7:0] req);
      logic [8:0]  w;
      logic [7:0]  en;
      @(posedge sys_clk);
      src_req <= req;
      repeat (2) @(posedge sys_clk);
      #1;
      w = model_win(req);
      for (int k = 0; k < 8; k++) begin
         en[k] = req[k] && (m[k / 4][(k % 4) * 8 + 2 +: 3] != 3'h0);
      end
      check(32'(irq_pending), 32'(w[8]));
      check(32'({irq_source, irq_level, irq_subpriority}), 32'(w[7:0]));
      axi_read(IPC_OFS_STATUS, d, r);
      check(d, {w[8], 7'h0, en, 5'h0, w[7:5], 3'h0, w[4:0]});
   endtask : check_irq

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, nrst} = '0;
      {awaddr, araddr, wstrb, wdata, src_req} = '0;
      m = '{default: '0};
      bad_count = 0;
      checked = 0;
      void'($urandom(32'h0b533e3a));
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      // Clear after reset; unmapped place refused
      for (i = 0; i < 2; i++) rd_check(4'(i * 4), 32'h0, IPC_RESP_OKAY);
      rd_check(4'hc, 32'h0, IPC_RESP_SLVERR);
      // Reserved bits never stored; strobes pick lanes; status and unmapped ignore writes
      axi_write(IPC_OFS_CTRL7, 32'hffffffff, 4'hf, IPC_RESP_OKAY);
      axi_write(IPC_OFS_CTRL8, 32'hffffffff, 4'hf, IPC_RESP_OKAY);
      axi_write(IPC_OFS_CTRL7, 32'h0, 4'h2, IPC_RESP_OKAY);
      axi_write(4'hc, 32'h0, 4'hf, IPC_RESP_SLVERR);
      axi_write(IPC_OFS_STATUS, 32'h0, 4'hf, IPC_RESP_OKAY);
      for (i = 0; i < 2; i++) rd_check(4'(i * 4), m[i], IPC_RESP_OKAY);
      // Every comparator code against the parallel port held at level 4, sub 2
      for (p = 0; p < 8; p++) begin
         for (s = 0; s < 4; s++) begin
            axi_write(IPC_OFS_CTRL7, 32'((p << 10) | (s << 8) | 8'h12), 4'hf,
                      IPC_RESP_OKAY);
            check_irq(8'h03);
         end
      end
      // Random lanes, reserved bits kept clear by software
      for (i = 0; i < 40; i++) begin
         axi_write(4'(($urandom % 2) * 4), $urandom & 32'h1f1f1f1f, 4'($urandom),
                   IPC_RESP_OKAY);
         check_irq(8'($urandom));
      end
      // Reset in mid-run clears both registers and silences all sources
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      m = '{default: '0};
      for (i = 0; i < 2; i++) rd_check(4'(i * 4), 32'h0, IPC_RESP_OKAY);
      check_irq(8'hff);
      stop_test();
   end
endmodule : tb
